// file: core/irbe_pkg.sv
// Overview of operation
// - byte increment adds one to destination; carry, decimal, half-carry kept
// - byte increment sets zero, sign from bit 7, overflow; else clears them
// - operand high nibble 1110b selects working register in current group
// - word increment adds one to even-addressed pair; A0 direct, A1 indirect, 10 cycles
// - word increment sets zero, sign, overflow; carry, decimal, half-carry kept
// - service return pops flags, then program counter; 16 cycles
// - service return finally sets global enable bit 7 of mask register
// - popped program counter: high byte at lower stack address
// - stack pointer low lives in register FFh; pops increment it
// - ccD absolute branch loads address when condition holds; 12 or 10 cycles
// - opcode 30 loads program counter from addressed pair; 8 cycles
// - relative branch adds sign-extended displacement when condition holds
// - relative target counts from byte after instruction; else falls through
// - branch condition 8 is always true
package irbe_pkg;
   // =========================================================
   // register file indices
   localparam logic [7:0] FLAG_IDX = 8'hfc;
   localparam logic [7:0] SPL_IDX = 8'hff;
   localparam logic [7:0] IMR_IDX = 8'hfb;
   localparam logic [7:0] RP_IDX = 8'hfd;
   localparam logic [7:0] REG_RST = 8'h00;
   localparam logic [3:0] WREG_NIB = 4'he;
   localparam logic [7:0] IMR_GIE = 8'h80;
   // =========================================================
   // flag bit positions
   localparam int FLG_C = 7;
   localparam int FLG_Z = 6;
   localparam int FLG_S = 5;
   localparam int FLG_V = 4;
   localparam int FLG_D = 3;
   localparam int FLG_H = 2;
   // =========================================================
   // opcodes
   localparam logic [7:0] OP_INC_R = 8'h20;
   localparam logic [7:0] OP_INC_IR = 8'h21;
   localparam logic [7:0] OP_ADD_ONE_PAIR_RR = 8'ha0;
   localparam logic [7:0] OP_ADD_ONE_PAIR_IR = 8'ha1;
   localparam logic [7:0] OP_RET = 8'hbf;
   localparam logic [7:0] OP_JP_IND = 8'h30;
   localparam logic [3:0] NIB_INC_W = 4'he;
   localparam logic [3:0] NIB_JP = 4'hd;
   localparam logic [3:0] NIB_JR = 4'hb;
   localparam logic [3:0] CC_ALWAYS = 4'h8;
   // =========================================================
   // cycle counts
   localparam logic [4:0] CYC_INC = 5'h06;
   localparam logic [4:0] CYC_ADD_ONE_PAIR = 5'h0a;
   localparam logic [4:0] CYC_RET = 5'h10;
   localparam logic [4:0] CYC_BR_T = 5'h0c;
   localparam logic [4:0] CYC_BR_N = 5'h0a;
   localparam logic [4:0] CYC_JP_IND = 5'h08;
   localparam logic [4:0] CNT_START = 5'h01;
   // =========================================================
   // control register indices, byte address is four times these
   localparam logic [9:0] CMD_IDX = 10'h100;
   localparam logic [9:0] PC_IDX = 10'h101;
   localparam logic [9:0] STAT_IDX = 10'h102;
   localparam logic [15:0] PC_RST = 16'h0000;
   localparam int ST_BUSY = 0;
   localparam int ST_ILL = 1;
   typedef enum logic {IRBE_IDLE, IRBE_EXEC} irbe_state_t;
endpackage : irbe_pkg

// file: core/irbe_cond.sv
`timescale 1ns/1ps
// =========================================================
// branch condition evaluation
module irbe_cond (
   input wire logic [7:0] flags_i,
   input wire logic [3:0] cc_i,
   output logic taken_o
);
   logic c, z, s, v, lt;
   always_comb begin
      c = flags_i[irbe_pkg::FLG_C];
      z = flags_i[irbe_pkg::FLG_Z];
      s = flags_i[irbe_pkg::FLG_S];
      v = flags_i[irbe_pkg::FLG_V];
      lt = s ^ v;
      unique case (cc_i)
         4'h0: taken_o = 1'b0;
         4'h1: taken_o = lt;
         4'h2: taken_o = z | lt;
         4'h3: taken_o = c | z;
         4'h4: taken_o = v;
         4'h5: taken_o = s;
         4'h6: taken_o = z;
         4'h7: taken_o = c;
         4'h8: taken_o = 1'b1;
         4'h9: taken_o = ~lt;
         4'ha: taken_o = ~(z | lt);
         4'hb: taken_o = ~(c | z);
         4'hc: taken_o = ~v;
         4'hd: taken_o = ~s;
         4'he: taken_o = ~z;
         4'hf: taken_o = ~c;
      endcase
   end
endmodule : irbe_cond

// file: core/irbe_core.sv
`timescale 1ns/1ps
module irbe_core (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   output logic busy_o,
   output logic [15:0] pc_o
);
   // =========================================================
   // state
   logic [7:0] rf_r [256];
   irbe_pkg::irbe_state_t state_r;
   logic [7:0] op_r, a_r, b_r;
   logic [15:0] pc_r;
   logic [4:0] cnt_r;
   logic ill_r;
   logic [31:0] prdata_r;
   logic pready_r, pslverr_r;

   logic [7:0] rp, fl, sp, dst, r8, fl_nxt;
   logic [15:0] w16, pc_nxt;
   logic [4:0] cyc;
   logic incb, add_one_pair, ret, jmp, ill, taken;
   logic [2:0] len;
   logic commit;

   function automatic logic [7:0] wadr(input logic [7:0] b, input logic [7:0] grp);
      wadr = (b[7:4] == irbe_pkg::WREG_NIB) ? {grp[7:4], b[3:0]} : b;
   endfunction : wadr

   assign rp = rf_r[irbe_pkg::RP_IDX];
   assign fl = rf_r[irbe_pkg::FLAG_IDX];
   assign sp = rf_r[irbe_pkg::SPL_IDX];
   assign commit = (state_r == irbe_pkg::IRBE_EXEC) && (cnt_r == cyc);

   irbe_cond u_cond (
      .flags_i(fl),
      .cc_i(op_r[7:4]),
      .taken_o(taken)
   );

   // =========================================================
   // decode and compute
   always_comb begin
      incb = 1'b0;
      add_one_pair = 1'b0;
      ret = 1'b0;
      jmp = 1'b0;
      ill = 1'b0;
      cyc = irbe_pkg::CYC_INC;
      len = 3'h1;
      dst = wadr(a_r, rp);
      if (op_r[3:0] == irbe_pkg::NIB_INC_W) begin
         incb = 1'b1;
         dst = {rp[7:4], op_r[7:4]};
      end else if (op_r == irbe_pkg::OP_INC_R) begin
         incb = 1'b1;
         len = 3'h2;
      end else if (op_r == irbe_pkg::OP_INC_IR) begin
         incb = 1'b1;
         len = 3'h2;
         dst = rf_r[wadr(a_r, rp)];
      end else if (op_r == irbe_pkg::OP_ADD_ONE_PAIR_RR) begin
         add_one_pair = 1'b1;
         len = 3'h2;
         cyc = irbe_pkg::CYC_ADD_ONE_PAIR;
      end else if (op_r == irbe_pkg::OP_ADD_ONE_PAIR_IR) begin
         add_one_pair = 1'b1;
         len = 3'h2;
         cyc = irbe_pkg::CYC_ADD_ONE_PAIR;
         dst = rf_r[wadr(a_r, rp)];
      end else if (op_r == irbe_pkg::OP_RET) begin
         ret = 1'b1;
         cyc = irbe_pkg::CYC_RET;
      end else if (op_r == irbe_pkg::OP_JP_IND) begin
         jmp = 1'b1;
         len = 3'h2;
         cyc = irbe_pkg::CYC_JP_IND;
      end else if (op_r[3:0] == irbe_pkg::NIB_JP) begin
         jmp = 1'b1;
         len = 3'h3;
         cyc = taken ? irbe_pkg::CYC_BR_T : irbe_pkg::CYC_BR_N;
      end else if (op_r[3:0] == irbe_pkg::NIB_JR) begin
         jmp = 1'b1;
         len = 3'h2;
         cyc = taken ? irbe_pkg::CYC_BR_T : irbe_pkg::CYC_BR_N;
      end else begin
         ill = 1'b1;
      end
   end

   always_comb begin
      r8 = rf_r[dst] + 8'h01;
      w16 = {rf_r[dst], rf_r[8'(dst + 8'h01)]} + 16'h0001;
      fl_nxt = fl;
      if (incb) begin
         fl_nxt[irbe_pkg::FLG_Z] = (r8 == 8'h00);
         fl_nxt[irbe_pkg::FLG_S] = r8[7];
         fl_nxt[irbe_pkg::FLG_V] = (r8 == 8'h80);
      end else if (add_one_pair) begin
         fl_nxt[irbe_pkg::FLG_Z] = (w16 == 16'h0000);
         fl_nxt[irbe_pkg::FLG_S] = w16[15];
         fl_nxt[irbe_pkg::FLG_V] = (w16 == 16'h8000);
      end else if (ret) begin
         fl_nxt = rf_r[sp];
      end
   end

   always_comb begin
      pc_nxt = pc_r + {13'h0000, len};
      if (ret) begin
         pc_nxt = {rf_r[8'(sp + 8'h01)], rf_r[8'(sp + 8'h02)]};
      end else if (op_r == irbe_pkg::OP_JP_IND) begin
         pc_nxt = {rf_r[dst], rf_r[8'(dst + 8'h01)]};
      end else if (jmp && taken && op_r[3:0] == irbe_pkg::NIB_JP) begin
         pc_nxt = {a_r, b_r};
      end else if (jmp && taken && op_r[3:0] == irbe_pkg::NIB_JR) begin
         pc_nxt = pc_r + {13'h0000, len} + {{8{a_r[7]}}, a_r};
      end
   end

   // =========================================================
   // apb decode
   logic [9:0] idx;
   logic setup, acc, map, err, wr;
   assign idx = paddr_i[11:2];
   assign setup = psel_i && !penable_i;
   assign acc = psel_i && penable_i && pready_r;
   assign map = (idx[9:8] == 2'b00) || idx == irbe_pkg::CMD_IDX ||
                idx == irbe_pkg::PC_IDX || idx == irbe_pkg::STAT_IDX;
   assign err = !map || (pwrite_i && busy_o && idx != irbe_pkg::STAT_IDX);
   assign wr = acc && pwrite_i && !pslverr_r;

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end else begin
         pready_r <= setup;
         pslverr_r <= setup && err;
         if (setup && !pwrite_i && map) begin
            if (idx[9:8] == 2'b00) begin
               prdata_r <= {24'h000000, rf_r[idx[7:0]]};
            end else if (idx == irbe_pkg::CMD_IDX) begin
               prdata_r <= {8'h00, b_r, a_r, op_r};
            end else if (idx == irbe_pkg::PC_IDX) begin
               prdata_r <= {16'h0000, pc_r};
            end else begin
               prdata_r <= {30'h0, ill_r, busy_o};
            end
         end else if (setup) begin
            prdata_r <= 32'h0000_0000;
         end
      end
   end

   // =========================================================
   // sequencer
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r <= irbe_pkg::IRBE_IDLE;
         cnt_r <= irbe_pkg::CNT_START;
         op_r <= 8'h00;
         a_r <= 8'h00;
         b_r <= 8'h00;
         busy_o <= 1'b0;
      end else begin
         unique case (state_r)
            irbe_pkg::IRBE_IDLE: begin
               if (wr && idx == irbe_pkg::CMD_IDX) begin
                  op_r <= pwdata_i[7:0];
                  a_r <= pwdata_i[15:8];
                  b_r <= pwdata_i[23:16];
                  cnt_r <= irbe_pkg::CNT_START;
                  state_r <= irbe_pkg::IRBE_EXEC;
                  busy_o <= 1'b1;
               end
            end
            irbe_pkg::IRBE_EXEC: begin
               if (commit) begin
                  state_r <= irbe_pkg::IRBE_IDLE;
                  busy_o <= 1'b0;
               end else begin
                  cnt_r <= cnt_r + 5'h01;
               end
            end
         endcase
      end
   end

   // =========================================================
   // register file
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < 256; i++) begin
            rf_r[i] <= irbe_pkg::REG_RST;
         end
      end else if (commit && !ill) begin
         rf_r[irbe_pkg::FLAG_IDX] <= fl_nxt;
         if (incb) begin
            rf_r[dst] <= r8;
         end
         if (add_one_pair) begin
            rf_r[dst] <= w16[15:8];
            rf_r[8'(dst + 8'h01)] <= w16[7:0];
         end
         if (ret) begin
            rf_r[irbe_pkg::SPL_IDX] <= sp + 8'h03;
            rf_r[irbe_pkg::IMR_IDX] <= rf_r[irbe_pkg::IMR_IDX] | irbe_pkg::IMR_GIE;
         end
      end else if (wr && idx[9:8] == 2'b00) begin
         rf_r[idx[7:0]] <= pwdata_i[7:0];
      end
   end

   // =========================================================
   // program counter and status
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pc_r <= irbe_pkg::PC_RST;
      end else if (commit && !ill) begin
         pc_r <= pc_nxt;
      end else if (wr && idx == irbe_pkg::PC_IDX) begin
         pc_r <= pwdata_i[15:0];
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ill_r <= 1'b0;
      end else if (commit && ill) begin
         ill_r <= 1'b1;
      end else if (wr && idx == irbe_pkg::STAT_IDX && pwdata_i[irbe_pkg::ST_ILL]) begin
         ill_r <= 1'b0;
      end
   end

   assign prdata_o = prdata_r;
   assign pready_o = pready_r;
   assign pslverr_o = pslverr_r;
   assign pc_o = pc_r;

   // =========================================================
   // assertions
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);

   inc_keep_cdh_a: assert property (commit && incb |=>
      fl[irbe_pkg::FLG_C] == $past(fl[irbe_pkg::FLG_C]) &&
      fl[irbe_pkg::FLG_D] == $past(fl[irbe_pkg::FLG_D]) &&
      fl[irbe_pkg::FLG_H] == $past(fl[irbe_pkg::FLG_H]))
      else $error("byte increment changed carry, decimal or half-carry");
   inc_zero_flag_a: assert property (commit && incb && rf_r[dst] == 8'hff |=>
      fl[irbe_pkg::FLG_Z] && !fl[irbe_pkg::FLG_S] && !fl[irbe_pkg::FLG_V])
      else $error("byte increment wrap flags wrong");
   wreg_map_a: assert property (state_r == irbe_pkg::IRBE_EXEC &&
      op_r == irbe_pkg::OP_INC_R && a_r[7:4] == 4'he |-> dst == {rp[7:4], a_r[3:0]})
      else $error("working register address wrong");
   add_one_pair_value_a: assert property (commit && add_one_pair && !ill |=>
      {rf_r[$past(dst)], rf_r[8'($past(dst) + 8'h01)]} ==
      $past({rf_r[dst], rf_r[8'(dst + 8'h01)]}) + 16'h0001)
      else $error("word increment result wrong");
   add_one_pair_ovf_a: assert property (commit && add_one_pair && w16 == 16'h8000 |=>
      fl[irbe_pkg::FLG_V] && fl[irbe_pkg::FLG_S] && !fl[irbe_pkg::FLG_Z])
      else $error("word increment overflow flags wrong");
   ret_pop_a: assert property (commit && ret |=>
      sp == $past(sp) + 8'h03 && fl == $past(rf_r[sp]) &&
      pc_r == {$past(rf_r[8'(sp + 8'h01)]), $past(rf_r[8'(sp + 8'h02)])})
      else $error("service return pop wrong");
   ret_gie_a: assert property (commit && ret |=> rf_r[irbe_pkg::IMR_IDX][7])
      else $error("global enable not set after return");
   jp_taken_time_a: assert property ($rose(busy_o) && op_r[3:0] == irbe_pkg::NIB_JP
      && taken |-> ##11 busy_o ##1 !busy_o)
      else $error("taken absolute branch not 12 cycles");
   jr_target_a: assert property (commit && op_r[3:0] == irbe_pkg::NIB_JR && taken |=>
      pc_r == $past(pc_r) + 16'h0002 + {{8{$past(a_r[7])}}, $past(a_r)})
      else $error("relative branch target wrong");
   always_cond_a: assert property (op_r[7:4] == irbe_pkg::CC_ALWAYS |-> taken)
      else $error("condition 8 not always true");
   jump_flags_a: assert property (commit && jmp |=> $stable(fl))
      else $error("branch changed flags");

   // =========================================================
   // results and timing per instruction
   inc_value_a: assert property (commit && incb |=>
      rf_r[$past(dst)] == $past(rf_r[dst]) + 8'h01)
      else $error("byte increment result wrong");
   inc_flags_a: assert property (commit && incb |=>
      fl[irbe_pkg::FLG_S] == rf_r[$past(dst)][7] && fl[irbe_pkg::FLG_Z] == (rf_r[$past(dst)] == 8'h00))
      else $error("byte increment sign or zero flag wrong");
   inc_time_a: assert property ($rose(busy_o) && incb |-> ##5 busy_o ##1 !busy_o)
      else $error("byte increment not 6 cycles");
   add_one_pair_time_a: assert property ($rose(busy_o) && add_one_pair |-> ##9 busy_o ##1 !busy_o)
      else $error("word increment not 10 cycles");
   add_one_pair_flags_a: assert property (commit && add_one_pair |=>
      fl[irbe_pkg::FLG_Z] == ({rf_r[$past(dst)], rf_r[8'($past(dst) + 8'h01)]} == 16'h0000) &&
      fl[irbe_pkg::FLG_S] == rf_r[$past(dst)][7])
      else $error("word increment sign or zero flag wrong");
   ret_time_a: assert property ($rose(busy_o) && ret |-> ##15 busy_o ##1 !busy_o)
      else $error("service return not 16 cycles");
   ret_spl_a: assert property (commit && ret |=>
      rf_r[irbe_pkg::SPL_IDX] == $past(rf_r[irbe_pkg::SPL_IDX]) + 8'h03)
      else $error("stack pointer low not advanced");
   ret_pc_a: assert property (commit && ret |=>
      pc_r[15:8] == $past(rf_r[8'(sp + 8'h01)]) && pc_r[7:0] == $past(rf_r[8'(sp + 8'h02)]))
      else $error("popped program counter byte order wrong");
   jp_target_a: assert property (commit && op_r[3:0] == irbe_pkg::NIB_JP && taken |=>
      pc_r == {$past(a_r), $past(b_r)})
      else $error("absolute branch target wrong");
   jp_not_time_a: assert property ($rose(busy_o) && op_r[3:0] == irbe_pkg::NIB_JP
      && !taken |-> ##9 busy_o ##1 !busy_o)
      else $error("untaken absolute branch not 10 cycles");
   jp_pair_a: assert property (commit && op_r == irbe_pkg::OP_JP_IND |=>
      pc_r == $past({rf_r[dst], rf_r[8'(dst + 8'h01)]}))
      else $error("pair branch target wrong");
   jp_ind_time_a: assert property ($rose(busy_o) && op_r == irbe_pkg::OP_JP_IND
      |-> ##7 busy_o ##1 !busy_o)
      else $error("pair branch not 8 cycles");
   jr_fall_a: assert property (commit && op_r[3:0] == irbe_pkg::NIB_JR && !taken |=>
      pc_r == $past(pc_r) + 16'h0002)
      else $error("relative branch fall through wrong");
   jr_time_a: assert property ($rose(busy_o) && op_r[3:0] == irbe_pkg::NIB_JR
      && taken |-> ##11 busy_o ##1 !busy_o)
      else $error("taken relative branch not 12 cycles");

   inc_cov_c: cover property (commit && incb);
   ret_cov_c: cover property (commit && ret);
   jr_cov_c: cover property (commit && op_r[3:0] == irbe_pkg::NIB_JR && taken);
   err_cov_c: cover property (pready_o && pslverr_o);
   ill_cov_c: cover property (commit && ill);
endmodule : irbe_core

// file: bench/testbench.sv
`timescale 1ns/1ps
// =========================================================
// bench for the increment, return and branch executor
module testbench;
   logic clk_sys_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0000_0000;
   logic [31:0] prdata_o;
   logic pready_o;
   logic pslverr_o;
   logic busy_o;
   logic [15:0] pc_o;
   int mismatches = 0;
   int n_tests = 0;
   logic [31:0] rdat;
   logic rerr;
   logic [7:0] fl;
   logic [7:0] disp;
   logic [15:0] ept;
   logic [7:0] flv [4] = '{8'h00, 8'hf0, 8'h50, 8'ha0};
   bit tk;

   always #2 clk_sys_i = ~clk_sys_i;

   irbe_core i_irbe_core (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .busy_o(busy_o),
      .pc_o(pc_o));

   // =========================================================
   // reporting
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : print_verdict

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   // =========================================================
   // apb master, holds the request until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge clk_sys_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_sys_i);
      penable_i <= 1'b1;
      k = 0;
      do begin
         @(posedge clk_sys_i);
         k++;
      end while (pready_o !== 1'b1 && k < 16);
      chk("pready", 32'h1, {31'h0, pready_o});
      rdat = prdata_o;
      rerr = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb

   task automatic wreg(input logic [7:0] i, input logic [7:0] v);
      apb(1'b1, {2'b00, i, 2'b00}, {24'h0, v});
   endtask : wreg

   task automatic rreg(input string n, input logic [7:0] i, input logic [7:0] e);
      apb(1'b0, {2'b00, i, 2'b00}, 32'h0);
      chk(n, {24'h0, e}, rdat);
   endtask : rreg

   task automatic setpc(input logic [15:0] v);
      apb(1'b1, {irbe_pkg::PC_IDX, 2'b00}, {16'h0, v});
   endtask : setpc

   // counts cycles of busy after the command write lands
   task automatic wait_done(input int n);
      int c;
      c = 0;
      #1;
      while (busy_o === 1'b1 && c < 64) begin
         @(posedge clk_sys_i);
         #1;
         c++;
      end
      if (n > 0) chk("cycles", n, c);
   endtask : wait_done

   task automatic run(input logic [7:0] op, input logic [7:0] a, input logic [7:0] b, input int n);
      apb(1'b1, {irbe_pkg::CMD_IDX, 2'b00}, {8'h00, b, a, op});
      wait_done(n);
   endtask : run

   task automatic ret_case(input logic [7:0] sp, input logic [7:0] f, input logic [15:0] pc,
                           input logic [7:0] irq_mask_reg, input bit probe);
      wreg(8'hff, sp);
      wreg(sp, f);
      wreg(sp + 8'h01, pc[15:8]);
      wreg(sp + 8'h02, pc[7:0]);
      wreg(8'hfb, irq_mask_reg);
      wreg(8'hfc, ~f);
      if (probe) begin
         apb(1'b1, {irbe_pkg::CMD_IDX, 2'b00}, 32'h0000_00bf);
         wreg(sp, 8'h00);
         chk("busy write err", 32'h1, {31'h0, rerr});
         apb(1'b0, {irbe_pkg::STAT_IDX, 2'b00}, 32'h0);
         chk("stat busy", 32'h1, {31'h0, rdat[0]});
         wait_done(0);
      end else begin
         run(8'hbf, 8'h00, 8'h00, 16);
      end
      chk("ret pc", {16'h0, pc}, {16'h0, pc_o});
      rreg("ret flags", 8'hfc, f);
      rreg("ret spl", 8'hff, sp + 8'h03);
      rreg("ret imr", 8'hfb, irq_mask_reg | 8'h80);
      rreg("stack kept", sp, f);
   endtask : ret_case

   function automatic bit cond_true(input logic [3:0] cc, input logic [7:0] f);
      bit b;
      case (cc[2:0])
         3'h0: b = 1'b0;
         3'h1: b = f[5] ^ f[4];
         3'h2: b = f[6] | (f[5] ^ f[4]);
         3'h3: b = f[7] | f[6];
         3'h4: b = f[4];
         3'h5: b = f[5];
         3'h6: b = f[6];
         default: b = f[7];
      endcase
      return b ^ cc[3];
   endfunction : cond_true

   // =========================================================
   // main sequence
   initial begin
      repeat (10) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      chk("pc reset", 32'h0, {16'h0, pc_o});
      rreg("flags reset", 8'hfc, 8'h00);
      apb(1'b0, 12'h40c, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, rerr});
      chk("unmapped data", 32'h0, rdat);
      wreg(8'hfc, 8'h8c);
      wreg(8'h40, 8'h7f);
      run(8'h20, 8'h40, 8'h00, 6);
      rreg("inc direct", 8'h40, 8'h80);
      rreg("inc flags v", 8'hfc, 8'hbc);
      wreg(8'hfd, 8'h10);
      wreg(8'h15, 8'h2a);
      wreg(8'he5, 8'h33);
      run(8'h20, 8'he5, 8'h00, 6);
      rreg("inc working", 8'h15, 8'h2b);
      rreg("inc abs kept", 8'he5, 8'h33);
      rreg("inc flags clr", 8'hfc, 8'h8c);
      wreg(8'h1a, 8'hff);
      run(8'hae, 8'h00, 8'h00, 6);
      rreg("inc short", 8'h1a, 8'h00);
      rreg("inc flags z", 8'hfc, 8'hcc);
      wreg(8'hb3, 8'hcb);
      wreg(8'hcb, 8'hcb);
      run(8'h21, 8'hb3, 8'h00, 6);
      rreg("inc indirect", 8'hcb, 8'hcc);
      rreg("inc flags s", 8'hfc, 8'hac);
      wreg(8'h30, 8'h7f);
      wreg(8'h31, 8'hff);
      run(8'ha0, 8'h30, 8'h00, 10);
      rreg("add_one_pair hi", 8'h30, 8'h80);
      rreg("add_one_pair lo", 8'h31, 8'h00);
      rreg("add_one_pair flags v", 8'hfc, 8'hbc);
      wreg(8'h10, 8'h32);
      wreg(8'h32, 8'hff);
      wreg(8'h33, 8'hff);
      run(8'ha1, 8'he0, 8'h00, 10);
      rreg("add_one_pair ind", 8'h32, 8'h00);
      rreg("add_one_pair flags z", 8'hfc, 8'hcc);
      ret_case(8'h45, 8'h5c, 16'h6fe4, 8'h0a, 1'b1);
      ret_case(8'h48, 8'ha3, 16'h1234, 8'h00, 1'b0);
      wreg(8'hfc, 8'h80);
      setpc(16'h0100);
      run(8'h7d, 8'h15, 8'h20, 12);
      chk("jp taken", 32'h1520, {16'h0, pc_o});
      wreg(8'hfc, 8'h00);
      setpc(16'h0100);
      run(8'h7d, 8'h15, 8'h20, 10);
      chk("jp not taken", 32'h0103, {16'h0, pc_o});
      wreg(8'h12, 8'h3f);
      wreg(8'h13, 8'h45);
      run(8'h30, 8'he2, 8'h00, 8);
      chk("jp pair", 32'h3f45, {16'h0, pc_o});
      setpc(16'h1000);
      run(8'h8b, 8'hd3, 8'h00, 12);
      chk("jr always", 32'h0fd5, {16'h0, pc_o});
      // every condition code against several flag patterns, both displacement limits
      for (int f = 0; f < 4; f++) begin
         for (int cc = 0; cc < 16; cc++) begin
            fl = flv[f];
            disp = cc[0] ? 8'h80 : 8'h7f;
            tk = cond_true(cc[3:0], fl);
            ept = tk ? 16'h1002 + {{8{disp[7]}}, disp} : 16'h1002;
            wreg(8'hfc, fl);
            setpc(16'h1000);
            run({cc[3:0], 4'hb}, disp, 8'h00, tk ? 12 : 10);
            chk("jr pc", {16'h0, ept}, {16'h0, pc_o});
            rreg("jr flags", 8'hfc, fl);
         end
      end
      // unknown opcode sets the sticky bit and changes nothing
      setpc(16'h0200);
      run(8'h00, 8'h00, 8'h00, 6);
      apb(1'b0, {irbe_pkg::STAT_IDX, 2'b00}, 32'h0);
      chk("ill set", 32'h2, rdat);
      chk("ill pc", 32'h0200, {16'h0, pc_o});
      apb(1'b1, {irbe_pkg::STAT_IDX, 2'b00}, 32'h2);
      apb(1'b0, {irbe_pkg::STAT_IDX, 2'b00}, 32'h0);
      chk("ill clr", 32'h0, rdat);
      print_verdict();
   end

   initial begin
      #200000;
      mismatches++;
      print_verdict();
   end
endmodule : testbench
